// *** nv_pkg.sv ***
// Shared constants for the nonvolatile byte store and its core-side agent
package nv_pkg;

  // ----------------------------------------------------------------
  // Storage geometry
  // ----------------------------------------------------------------
  localparam int unsigned NV_DEPTH = 128;
  localparam int unsigned NV_AW    = 7;
  localparam int unsigned NV_DW    = 8;
  localparam logic [7:0]  NV_ERASED = 8'hff;

  // ----------------------------------------------------------------
  // I/O register selects and control bits
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_ADDR = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_CTRL = 2'h2;

  localparam int unsigned CTRL_RSTROBE_BIT = 0;
  localparam int unsigned CTRL_WSTROBE_BIT = 1;
  localparam int unsigned CTRL_ARM_BIT     = 2;
  localparam int unsigned CTRL_IRQEN_BIT   = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [2:0]  NV_ARM_CYCLES       = 3'h4;
  localparam logic [2:0]  NV_WR_STALL         = 3'h2;
  localparam logic [2:0]  NV_RD_STALL         = 3'h4;
  localparam int unsigned NV_CLK_HZ           = 200_000_000;
  localparam int unsigned NV_OSC_HZ           = 1_000_000;
  localparam int unsigned NV_TICK_DIV         = NV_CLK_HZ / NV_OSC_HZ;
  localparam int unsigned NV_WRITE_OSC_CYCLES = 8448;

  // ----------------------------------------------------------------
  // Core agent APB map
  // ----------------------------------------------------------------
  localparam logic [31:0] APB_REQ  = 32'h0000_0000;
  localparam logic [31:0] APB_STAT = 32'h0000_0004;
  localparam logic [31:0] APB_CFG  = 32'h0000_0008;

  localparam int unsigned REQ_ADDR_LSB  = 0;
  localparam int unsigned REQ_DATA_LSB  = 8;
  localparam int unsigned REQ_OP_LSB    = 16;
  localparam logic [1:0]  OP_WRITE_BYTE = 2'h1;
  localparam logic [1:0]  OP_READ_BYTE  = 2'h2;

  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_IRQ_BIT   = 1;
  localparam int unsigned STAT_STALL_BIT = 2;
  localparam int unsigned STAT_DATA_LSB  = 8;

  localparam int unsigned CFG_GIE_BIT   = 0;
  localparam int unsigned CFG_IRQEN_BIT = 1;

endpackage : nv_pkg

// *** nv_io_if.sv ***
// Core I/O port between the processor agent and the byte store
`timescale 1ns/10ps
`default_nettype none

interface nv_io_if (
  input wire logic ref_clk_i
);

  logic [1:0] sel;
  logic       wr;
  logic [7:0] wdata;
  logic       gie;
  logic [7:0] rdata;
  logic       stall;
  logic       ready_irq;

  modport dev (
    input  sel, wr, wdata, gie,
    output rdata, stall, ready_irq
  );

  modport core (
    output sel, wr, wdata, gie,
    input  rdata, stall, ready_irq
  );

endinterface : nv_io_if

`default_nettype wire

// *** nv_write_engine.sv ***
// Self-timed write engine and byte array, kept alive across core reset
`timescale 1ns/10ps
`default_nettype none

module nv_write_engine #(
  parameter int unsigned TICK_DIV    = nv_pkg::NV_TICK_DIV,
  parameter int unsigned WRITE_TICKS = nv_pkg::NV_WRITE_OSC_CYCLES
) (
  // Clock and power-on reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     por_n_i,
  // Commands
  input  wire logic                     start_i,
  input  wire logic                     abort_i,
  input  wire logic [nv_pkg::NV_AW-1:0] addr_i,
  input  wire logic [nv_pkg::NV_DW-1:0] data_i,
  // State
  output logic                          busy_o,
  output logic [nv_pkg::NV_DW-1:0]      rdata_o
);
  import nv_pkg::*;

  localparam int unsigned DIV_W = $clog2(TICK_DIV + 1);
  localparam int unsigned CNT_W = $clog2(WRITE_TICKS + 1);

  typedef struct packed {
    logic [NV_DEPTH-1:0][NV_DW-1:0] mem;
    logic                           busy;
    logic [NV_AW-1:0]               addr;
    logic [NV_DW-1:0]               data;
    logic [DIV_W-1:0]               div;
    logic [CNT_W-1:0]               ticks;
  } eng_state_t;

  localparam eng_state_t ENG_RST = '{mem: {NV_DEPTH{NV_ERASED}}, default: '0};

  eng_state_t q;
  eng_state_t d;

  // ----------------------------------------------------------------
  // Write timing off a 1 MHz tick derived from the system clock
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (q.busy) begin
      if (q.div == DIV_W'(TICK_DIV - 1)) begin
        d.div   = '0;
        d.ticks = q.ticks + CNT_W'(1);
      end else begin
        d.div = q.div + DIV_W'(1);
      end
      if (q.ticks == CNT_W'(WRITE_TICKS)) begin
        d.busy        = 1'b0;
        d.mem[q.addr] = q.data;
      end
    end
    // Abort drops the write and the cell keeps its old byte, except in the last busy cycle, when the new byte still lands
    if (abort_i) begin
      d.busy = 1'b0;
    end else if (start_i && !q.busy) begin
      d.busy  = 1'b1;
      d.addr  = addr_i;
      d.data  = data_i;
      d.div   = '0;
      d.ticks = '0;
    end
  end

  // Only power-on clears this state, so a core reset cannot cut a write
  always_ff @(posedge ref_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      q <= ENG_RST;
    end else begin
      q <= d;
    end
  end

  assign busy_o  = q.busy;
  assign rdata_o = q.mem[addr_i];

endmodule : nv_write_engine

`default_nettype wire

// *** nv_store_ctrl.sv ***
// Device end: 128-byte nonvolatile store behind address, data and control registers
`timescale 1ns/10ps
`default_nettype none

module nv_store_ctrl #(
  parameter int unsigned TICK_DIV    = nv_pkg::NV_TICK_DIV,
  parameter int unsigned WRITE_TICKS = nv_pkg::NV_WRITE_OSC_CYCLES
) (
  // Clock and resets
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic por_n_i,
  // Core I/O port
  nv_io_if.dev      io,
  // System status
  output logic      write_busy_o
);
  import nv_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NV_AW-1:0] addr;
    logic [NV_DW-1:0] data;
    logic             irq_en;
    logic             arm;
    logic [2:0]       arm_cnt;
    logic             rd_pend;
    logic [2:0]       stall_cnt;
    logic             stall;
    logic             irq;
    logic [7:0]       rdata;
  } dev_state_t;

  dev_state_t       q;
  dev_state_t       d;
  logic             start;
  logic             abort;
  logic             busy;
  logic [NV_DW-1:0] cell_byte;

  // ----------------------------------------------------------------
  // Register view
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_view(input logic [1:0] sel,
                                          input dev_state_t s,
                                          input logic       wbusy);
    logic [7:0] v;
    v = 8'h00;
    case (sel)
      SEL_ADDR: v = {1'b0, s.addr};
      SEL_DATA: v = s.data;
      SEL_CTRL: begin
        v                   = 8'h00;
        v[CTRL_IRQEN_BIT]   = s.irq_en;
        v[CTRL_ARM_BIT]     = s.arm;
        v[CTRL_WSTROBE_BIT] = wbusy;
        v[CTRL_RSTROBE_BIT] = s.rd_pend;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_view

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d     = q;
    start = 1'b0;
    abort = 1'b0;

    // Arm window: high for exactly four cycles after it is set
    if (q.arm) begin
      if (q.arm_cnt == 3'h1) begin
        d.arm = 1'b0;
      end
      d.arm_cnt = q.arm_cnt - 3'h1;
    end

    // A read completes the cycle after its strobe
    if (q.rd_pend) begin
      d.data    = cell_byte;
      d.rd_pend = 1'b0;
    end

    if (q.stall_cnt != 3'h0) begin
      d.stall_cnt = q.stall_cnt - 3'h1;
    end

    if (io.wr) begin
      case (io.sel)
        SEL_ADDR: begin
          d.addr = io.wdata[NV_AW-1:0];
          abort  = busy;
        end
        SEL_DATA: begin
          d.data = io.wdata;
          abort  = busy;
        end
        SEL_CTRL: begin
          d.irq_en = io.wdata[CTRL_IRQEN_BIT];
          if (io.wdata[CTRL_ARM_BIT]) begin
            d.arm     = 1'b1;
            d.arm_cnt = NV_ARM_CYCLES;
          end
          // Unarmed strobe, or a strobe during a write, is ignored
          if (io.wdata[CTRL_WSTROBE_BIT] && q.arm && !busy) begin
            start       = 1'b1;
            d.stall_cnt = NV_WR_STALL;
          end
          if (io.wdata[CTRL_RSTROBE_BIT]) begin
            d.rd_pend   = 1'b1;
            d.stall_cnt = NV_RD_STALL;
          end
        end
        default: begin
        end
      endcase
    end

    d.stall = (d.stall_cnt != 3'h0);
    // Level, not pulse: stays up while gie and irq_en are set and no write runs
    d.irq   = io.gie && d.irq_en && !(busy || start);
    d.rdata = reg_view(io.sel, q, busy);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Write engine and byte array
  // ----------------------------------------------------------------
  nv_write_engine #(
    .TICK_DIV    (TICK_DIV),
    .WRITE_TICKS (WRITE_TICKS)
  ) u_engine (
    .ref_clk_i (ref_clk_i),
    .por_n_i   (por_n_i),
    .start_i   (start),
    .abort_i   (abort),
    .addr_i    (q.addr),
    .data_i    (q.data),
    .busy_o    (busy),
    .rdata_o   (cell_byte)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io.rdata     = q.rdata;
  assign io.stall     = q.stall;
  assign io.ready_irq = q.irq;
  assign write_busy_o = busy;

endmodule : nv_store_ctrl

`default_nettype wire

// *** nv_core_agent.sv ***
// Core end: APB-controlled agent that runs byte reads and writes on the store
`timescale 1ns/10ps
`default_nettype none

module nv_core_agent (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Store I/O port
  nv_io_if.core            io
);
  import nv_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_POLL, ST_POLL_W, ST_POLL_CHK, ST_WADDR, ST_WDATA, ST_WARM,
    ST_WSTRB, ST_RADDR, ST_RSTRB, ST_RSEL, ST_RSEL_W, ST_RCAP
  } core_st_t;

  typedef struct packed {
    core_st_t         st;
    logic [1:0]       op;
    logic [NV_AW-1:0] addr;
    logic [NV_DW-1:0] data;
    logic [NV_DW-1:0] rd_byte;
    logic             gie;
    logic             irq_en;
    logic [1:0]       sel;
    logic             wr;
    logic [7:0]       wdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } core_state_t;

  core_state_t q;
  core_state_t d;
  logic        ready;

  function automatic logic [7:0] ctrl_word(input logic ie, input int unsigned bitpos);
    logic [7:0] v;
    v                 = 8'h00;
    v[CTRL_IRQEN_BIT] = ie;
    v[bitpos]         = 1'b1;
    return v;
  endfunction : ctrl_word

  // ----------------------------------------------------------------
  // Sequencer and APB slave
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.wr    = 1'b0;
    d.pready = 1'b0;
    // One idle cycle after each access lets a stall become visible
    ready   = !q.wr && !io.stall;
    case (q.st)
      ST_IDLE: begin
      end
      ST_POLL: if (ready) begin
        d.sel = SEL_CTRL;
        d.st  = ST_POLL_W;
      end
      ST_POLL_W: d.st = ST_POLL_CHK;
      ST_POLL_CHK: begin
        if (io.rdata[CTRL_WSTROBE_BIT]) begin
          d.st = ST_POLL;
        end else begin
          d.st = (q.op == OP_WRITE_BYTE) ? ST_WADDR : ST_RADDR;
        end
      end
      ST_WADDR, ST_RADDR: if (ready) begin
        d.wr    = 1'b1;
        d.sel   = SEL_ADDR;
        d.wdata = {1'b0, q.addr};
        d.st    = (q.st == ST_WADDR) ? ST_WDATA : ST_RSTRB;
      end
      ST_WDATA: if (ready) begin
        d.wr    = 1'b1;
        d.sel   = SEL_DATA;
        d.wdata = q.data;
        d.st    = ST_WARM;
      end
      ST_WARM: if (ready) begin
        d.wr    = 1'b1;
        d.sel   = SEL_CTRL;
        d.wdata = ctrl_word(q.irq_en, CTRL_ARM_BIT);
        d.st    = ST_WSTRB;
      end
      ST_WSTRB: if (!q.wr) begin
        d.wr    = 1'b1;
        d.wdata = ctrl_word(q.irq_en, CTRL_WSTROBE_BIT);
        d.st    = ST_IDLE;
      end
      ST_RSTRB: if (ready) begin
        d.wr    = 1'b1;
        d.sel   = SEL_CTRL;
        d.wdata = ctrl_word(q.irq_en, CTRL_RSTROBE_BIT);
        d.st    = ST_RSEL;
      end
      ST_RSEL: if (ready) begin
        d.sel = SEL_DATA;
        d.st  = ST_RSEL_W;
      end
      ST_RSEL_W: d.st = ST_RCAP;
      ST_RCAP: begin
        d.rd_byte = io.rdata;
        d.st      = ST_IDLE;
      end
      default: d.st = ST_IDLE;
    endcase

    if (psel_i && penable_i && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = 1'b0;
      d.prdata  = 32'h0000_0000;
      case (paddr_i)
        APB_REQ: begin
          d.prdata[REQ_ADDR_LSB +: NV_AW] = q.addr;
          d.prdata[REQ_DATA_LSB +: NV_DW] = q.data;
          d.prdata[REQ_OP_LSB +: 2]       = q.op;
          // A new request while busy is dropped
          if (pwrite_i && q.st == ST_IDLE) begin
            d.addr = pwdata_i[REQ_ADDR_LSB +: NV_AW];
            d.data = pwdata_i[REQ_DATA_LSB +: NV_DW];
            d.op   = pwdata_i[REQ_OP_LSB +: 2];
            if (d.op == OP_WRITE_BYTE || d.op == OP_READ_BYTE) begin
              d.st = ST_POLL;
            end
          end
        end
        APB_STAT: begin
          d.prdata[STAT_BUSY_BIT]              = (q.st != ST_IDLE) || q.wr;
          d.prdata[STAT_IRQ_BIT]               = io.ready_irq;
          d.prdata[STAT_STALL_BIT]             = io.stall;
          d.prdata[STAT_DATA_LSB +: NV_DW]     = q.rd_byte;
        end
        APB_CFG: begin
          d.prdata[CFG_GIE_BIT]   = q.gie;
          d.prdata[CFG_IRQEN_BIT] = q.irq_en;
          if (pwrite_i) begin
            d.gie    = pwdata_i[CFG_GIE_BIT];
            d.irq_en = pwdata_i[CFG_IRQEN_BIT];
          end
        end
        default: d.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{st: ST_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io.sel    = q.sel;
  assign io.wr     = q.wr;
  assign io.wdata  = q.wdata;
  assign io.gie    = q.gie && (q.st == ST_IDLE);
  assign prdata_o  = q.prdata;
  assign pready_o  = q.pready;
  assign pslverr_o = q.pslverr;

endmodule : nv_core_agent

`default_nettype wire

// *** nv_store_chk.sv ***
// Checker for the core I/O port between agent and byte store
`timescale 1ns/10ps
`default_nettype none

module nv_store_chk (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       nrst_i,
  // Core I/O port
  input wire logic [1:0] sel,
  input wire logic       wr,
  input wire logic [7:0] wdata,
  input wire logic       gie,
  input wire logic [7:0] rdata,
  input wire logic       stall,
  input wire logic       ready_irq
);
  import nv_pkg::*;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic ctrl_wr;
  assign ctrl_wr = wr && (sel == SEL_CTRL);

  // ----------------------------------------------------------------
  // Stall timing
  // ----------------------------------------------------------------
  rd_stall_len_a: assert property (ctrl_wr && wdata[0] |=> stall [*4] ##1 !stall)
    else $error("read strobe stall not four cycles");
  wr_stall_len_a: assert property (ctrl_wr && wdata[1] && !wdata[0]
      && $past(ctrl_wr && wdata[2], 2) |=> stall [*2] ##1 !stall)
    else $error("write start stall not two cycles");
  arm_no_stall_a: assert property (ctrl_wr && wdata[2] && (wdata[1:0] == 2'h0) |=> !stall)
    else $error("arm alone stalled the core");
  stall_cause_a: assert property ($rose(stall) |-> $past(ctrl_wr && (wdata[1:0] != 2'h0)))
    else $error("stall without a strobe write");

  // ----------------------------------------------------------------
  // Readback and ready interrupt
  // ----------------------------------------------------------------
  ctrl_rsv_zero_a: assert property ($past(sel) == SEL_CTRL |-> rdata[7:4] == 4'h0)
    else $error("control reserved bits not zero");
  addr_top_zero_a: assert property ($past(sel) == SEL_ADDR |-> !rdata[7])
    else $error("address bit seven not zero");
  irq_needs_gie_a: assert property (ready_irq |-> $past(gie))
    else $error("ready interrupt without global enable");
  irq_write_drop_a: assert property (ctrl_wr && wdata[1]
      && $past(ctrl_wr && wdata[2], 2) |-> ##[2:3] !ready_irq)
    else $error("ready interrupt held during write");

  rd_seen_c: cover property (ctrl_wr && wdata[0]);
  wr_seen_c: cover property (ctrl_wr && wdata[1]);
  irq_seen_c: cover property (ready_irq);

endmodule : nv_store_chk

`default_nettype wire

// *** eeprom_byte_access_controller_tb.sv ***
// Bench joining the core agent and the byte store across the I/O port
`timescale 1ns/10ps
`default_nettype none

module eeprom_byte_access_controller_tb;
  import nv_pkg::*;

  // Shortened write timing: 8 ticks of 4 clocks
  localparam int unsigned TDIV   = 4;
  localparam int unsigned WTICKS = 8;
  localparam int unsigned LIMIT  = 20000;

  logic        ref_clk_i;
  logic        nrst_i;
  logic        por_n_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        write_busy;
  int          err_total;
  int          samples_checked;
  int          cyc      = 0;
  int          busy_cyc = 0;

  nv_io_if io_bus (.ref_clk_i(ref_clk_i));

  nv_store_ctrl #(.TICK_DIV(TDIV), .WRITE_TICKS(WTICKS)) u_nv_store_ctrl (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .por_n_i(por_n_i),
    .io(io_bus), .write_busy_o(write_busy));

  nv_core_agent u_nv_core_agent (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .io(io_bus));

  nv_store_chk u_nv_store_chk (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sel(io_bus.sel), .wr(io_bus.wr),
    .wdata(io_bus.wdata), .gie(io_bus.gie), .rdata(io_bus.rdata),
    .stall(io_bus.stall), .ready_irq(io_bus.ready_irq));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // Hang guard and write duration counter
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (write_busy === 1'b1) begin
      busy_cyc <= busy_cyc + 1;
    end
    if (cyc == LIMIT) begin
      err_total++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Pready is never assumed: only the global guard ends the wait
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, input logic exp_err);
    @(posedge ref_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    r = prdata;
    chk({31'h0, pslverr}, {31'h0, exp_err});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic idle();
    logic [31:0] r;
    int          n;
    n = 0;
    r = 32'h1;
    while (r[STAT_BUSY_BIT] !== 1'b0 && n < 200) begin
      apb(1'b0, APB_STAT, 32'h0, r, 1'b0);
      n++;
    end
  endtask : idle

  task automatic wait_store(input logic lvl);
    int n;
    n = 0;
    while (write_busy !== lvl && n < 500) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk({31'h0, write_busy}, {31'h0, lvl});
  endtask : wait_store

  task automatic nv_op(input logic [1:0] op, input logic [6:0] a, input logic [7:0] d);
    logic [31:0] r;
    idle();
    apb(1'b1, APB_REQ, {14'h0, op, d, 1'b0, a}, r, 1'b0);
    idle();
  endtask : nv_op

  task automatic read_expect(input logic [6:0] a, input logic [7:0] exp);
    logic [31:0] r;
    nv_op(OP_READ_BYTE, a, 8'h00);
    apb(1'b0, APB_STAT, 32'h0, r, 1'b0);
    chk({24'h0, r[15:8]}, {24'h0, exp});
  endtask : read_expect

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    apb(1'b0, APB_CFG, 32'h0, r, 1'b0);
    chk(r, 32'h0);
    apb(1'b0, 32'h0000_000c, 32'h0, r, 1'b1);
    chk(r, 32'h0);
    read_expect(7'h03, NV_ERASED);
    // Request fields read back as stored; stall low once idle
    apb(1'b0, APB_REQ, 32'h0, r, 1'b0);
    chk(r, {14'h0, OP_READ_BYTE, 8'h00, 8'h03});
    apb(1'b0, APB_STAT, 32'h0, r, 1'b0);
    chk({31'h0, r[STAT_STALL_BIT]}, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_write_read();
    logic [6:0] addrs [3];
    logic [7:0] datas [3];
    int         b0;
    addrs = '{7'h00, 7'h7f, 7'h40};
    datas = '{8'ha5, 8'h5a, 8'h00};
    for (int i = 0; i < 3; i++) begin
      b0 = busy_cyc;
      nv_op(OP_WRITE_BYTE, addrs[i], datas[i]);
      wait_store(1'b0);
      b0 = busy_cyc - b0;
      chk(b0 >= WTICKS * TDIV && b0 <= (WTICKS + 2) * TDIV, 1);
    end
    for (int i = 0; i < 3; i++) begin
      read_expect(addrs[i], datas[i]);
    end
    $display("test write_read done");
  endtask : t_write_read

  task automatic t_ready_irq();
    logic [31:0] r;
    for (int c = 1; c <= 3; c++) begin
      apb(1'b1, APB_CFG, c, r, 1'b0);
      apb(1'b0, APB_CFG, 32'h0, r, 1'b0);
      chk(r, c);
      nv_op(OP_WRITE_BYTE, 7'h11, 8'(c));
      wait_store(1'b0);
      repeat (3) @(posedge ref_clk_i);
      chk({31'h0, io_bus.ready_irq}, {31'h0, c == 3});
      apb(1'b0, APB_STAT, 32'h0, r, 1'b0);
      chk({31'h0, r[STAT_IRQ_BIT]}, {31'h0, c == 3});
    end
    apb(1'b1, APB_CFG, 32'h0, r, 1'b0);
    $display("test ready_irq done");
  endtask : t_ready_irq

  task automatic t_reset_write();
    logic [31:0] r;
    idle();
    apb(1'b1, APB_REQ, {14'h0, OP_WRITE_BYTE, 8'h3c, 1'b0, 7'h0a}, r, 1'b0);
    wait_store(1'b1);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    chk({31'h0, write_busy}, 32'h1);
    wait_store(1'b0);
    read_expect(7'h0a, 8'h3c);
    $display("test reset_write done");
  endtask : t_reset_write

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    err_total       = 0;
    samples_checked = 0;
    nrst_i          = 1'b0;
    por_n_i         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 32'h0;
    pwdata          = 32'h0;
    repeat (12) @(posedge ref_clk_i);
    nrst_i  <= 1'b1;
    por_n_i <= 1'b1;
    t_regs();
    t_write_read();
    t_ready_irq();
    t_reset_write();
    print_verdict();
  end

endmodule : eeprom_byte_access_controller_tb

`default_nettype wire
